// ### rtl/irq_consts.svh
/*
 * constants of the vectored interrupt block: register offsets, field
 * positions, reset values, vector addresses.
 * assumes inclusion by bare name from package and modules.
 */
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
// register byte addresses on apb; request register sits at word index
// 0xfa, so its byte address is four times that index
`define IDX_REQ_EDGE   10'h0fa
`define OFS_REQ_EDGE   {`IDX_REQ_EDGE, 2'b00}
`define OFS_PRIORITY   12'h004
`define OFS_MASK       12'h008
`define OFS_PORT3_MODE 12'h00c
`define OFS_PIN_LEVEL  12'h010
`define OFS_VECTOR     12'h014
`define OFS_INT_STAT   12'h018
`define OFS_INT_MASK   12'h01c
`define OFS_CORE_CTRL  12'h020
// request register edge field positions
`define BIT_EDGE_TWO   7
`define BIT_EDGE_ZERO  6
// port 3 mode analog enable bit
`define BIT_ANALOG_EN  1
// core control: global interrupt enable, timer input select
`define BIT_GLOBAL_EN  0
`define BIT_TIN_SEL    1
// reset values
`define RST_BYTE       8'h00
`define RST_PRIO       3'h0
`define RST_VEC        16'h0000
// vector byte addresses of the six requests
`define VEC_ZERO       16'h0000
`define VEC_ONE        16'h0002
`define VEC_TWO        16'h0004
`define VEC_THREE      16'h0006
`define VEC_FOUR       16'h0008
`define VEC_FIVE       16'h000a
// number of request sources
`define NUM_REQ        6
`endif

// ### rtl/irq_pkg.sv
/*
 * types of the vectored interrupt block.
 * assumes irq_consts.svh is on the include path.
 */
package irq_pkg;
`include "irq_consts.svh"
    // machine states of the interrupt cycle
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_SAVE  = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_JUMP  = 4'b1000
    } irq_state_t;
    // request to the core sequencer
    typedef struct packed
    {
        logic        branch;   // one-cycle branch pulse
        logic        save;     // one-cycle save pc and flags pulse
        logic [15:0] vector;   // assembled 16-bit branch vector
        logic [2:0]  source;   // granted source number
    } core_req_t;
endpackage

// ### rtl/edge_sel.sv
/*
 * edge detector for one external request: rising, falling or both.
 * assumes a synchronised input on clk_sys.
 */
`timescale 1ns/1ns
module edge_sel
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic level,
    input  wire logic onRise,
    input  wire logic onFall,
    output logic      hit
);
    logic lastLevel_reg;   // level one cycle earlier

    // remember previous level
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            lastLevel_reg <= 1'b0;
        else
            lastLevel_reg <= level;
    end

    // one-cycle pulse on a selected transition
    assign hit = (onRise & level & ~lastLevel_reg)
               | (onFall & ~level & lastLevel_reg);
endmodule // edge_sel

// ### rtl/vectored_irq.sv
/*
 * vectored interrupt controller: six sources, edge selection, priority,
 * interrupt machine cycle and 16-bit vector fetch, apb registers.
 * assumes a core sequencer that answers vector fetches with vecReady
 * and analog comparator outputs already digital on clk_sys-free pins.
 */
// Register access over APB was chosen for this implementation.
// How it works
// R1: requests zero, two edge-selectable, vectors 0,4
// R2: request one falling edge only, vector 2
// R3: timers and voltage detector vector 6,8,10
// R4: programmable priority picks among pending requests
// R5: grant saves pc, flags, disables interrupts
// R6: two vector bytes form 16-bit branch address
// R7: masked requests still latch for polling
// R8: comparator one to two, two to zero
// R9: edge bits are request register D7, D6
// R10: edge code 00 01 10 11 decoded
// R11: software reads raw request pin levels
// R12: analog compare only when port3 bit1 set
// R13: timer edge input from pin one or port2
// R14: pending set by event, cleared grant/write
`timescale 1ns/1ns
module vectored_irq
    import irq_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comparatorPinOne,
    input  wire logic        comparatorPinTwo,
    input  wire logic        referencePinThree,
    input  wire logic        portTwoBitZero,
    input  wire logic        analogComparatorOne,
    input  wire logic        analogComparatorTwo,
    input  wire logic        sixteenBitTimer,
    input  wire logic        eightBitTimer,
    input  wire logic        lowVoltageDetector,
    input  wire logic [7:0]  vecByte,
    input  wire logic        vecReady,
    output core_req_t        coreReq,
    output logic             vecFetch,
    output logic [15:0]      vecAddr,
    output logic             timerInput,
    output logic             irq
);
    // synchronisers for all pins: stage one read only by stage two
    logic [8:0] pinMeta_reg;        // first stage
    logic [8:0] pinSync_reg;        // second stage
    logic [8:0] pinRaw;             // raw pins gathered
    assign pinRaw = {lowVoltageDetector, eightBitTimer, sixteenBitTimer,
                     analogComparatorTwo, analogComparatorOne,
                     portTwoBitZero, referencePinThree,
                     comparatorPinTwo, comparatorPinOne};
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pinMeta_reg <= 9'h000;
            pinSync_reg <= 9'h000;
        end
        else
        begin
            pinMeta_reg <= pinRaw;
            pinSync_reg <= pinMeta_reg;
        end
    end

    // registers
    logic [7:0]  reqEdge_reg;       // D7,D6 edges, D5..D0 pending
    logic [2:0]  priority_reg;      // priority ordering select
    logic [5:0]  mask_reg;          // per-source enable
    logic [7:0]  port3Mode_reg;     // port 3 mode, bit 1 analog
    logic [1:0]  coreCtrl_reg;      // global enable, timer select
    logic [1:0]  intStat_reg;       // sticky: grant, fetch done
    logic [1:0]  intMask_reg;       // interrupt mask
    logic [15:0] vector_reg;        // last assembled vector
    logic        globalEn_reg;      // cleared by machine cycle

    // analog enable selects comparator outputs over raw pins
    logic analogOn;
    logic srcZero;
    logic srcTwo;
    logic srcOne;
    assign analogOn = port3Mode_reg[`BIT_ANALOG_EN];   // [R12]
    assign srcZero  = analogOn ? pinSync_reg[5] : pinSync_reg[1]; // [R8]
    assign srcTwo   = analogOn ? pinSync_reg[4] : pinSync_reg[0]; // [R8]
    assign srcOne   = pinSync_reg[2];

    // timer edge input from pin one or port two bit zero
    assign timerInput = coreCtrl_reg[`BIT_TIN_SEL] ? pinSync_reg[3]
                                                    : pinSync_reg[0]; // [R13]

    // edge choice decode from request register
    logic eTwo;
    logic eZero;
    logic zeroRise;
    logic zeroFall;
    logic twoRise;
    logic twoFall;
    assign eTwo     = reqEdge_reg[`BIT_EDGE_TWO];  // [R9]
    assign eZero    = reqEdge_reg[`BIT_EDGE_ZERO]; // [R9]
    assign twoRise  = eTwo;                        // [R10]
    assign twoFall  = ~eTwo | eZero;               // [R10]
    assign zeroRise = eZero;                       // [R10]
    assign zeroFall = ~eZero | eTwo;               // [R10]

    // source events
    logic [5:0] event_w;      // one-cycle event per source
    logic [5:0] edgeLevel;    // detector inputs
    logic [5:0] edgeRise;
    logic [5:0] edgeFall;
    assign edgeLevel = {pinSync_reg[8], pinSync_reg[7], pinSync_reg[6],
                        srcTwo, srcOne, srcZero};
    assign edgeRise  = {3'h7, twoRise, 1'b0, zeroRise};        // [R1] [R3]
    assign edgeFall  = {3'h0, twoFall, 1'b1, zeroFall};        // [R1] [R2]
    // internal sources are rising-edge events
    genvar g;
    generate
        for (g = 0; g < `NUM_REQ; g++)
        begin : gEdge
            edge_sel uEdge
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .level   (edgeLevel[g]),
                .onRise  (edgeRise[g]),
                .onFall  (edgeFall[g]),
                .hit     (event_w[g])
            );
        end
    endgenerate

    // apb decode
    logic apbWrite;
    logic apbRead;
    logic mapped;
    assign apbWrite = psel & penable & pwrite;
    assign apbRead  = psel & penable & ~pwrite;
    assign pready   = 1'b1;
    always_comb
    begin
        mapped = 1'b1;
        unique case (paddr)
            `OFS_REQ_EDGE, `OFS_PRIORITY, `OFS_MASK, `OFS_PORT3_MODE,
            `OFS_PIN_LEVEL, `OFS_VECTOR, `OFS_INT_STAT, `OFS_INT_MASK,
            `OFS_CORE_CTRL: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    // interrupt machine
    irq_state_t state_reg;
    irq_state_t state_next;
    logic [2:0] grantSrc_reg;   // source under service
    logic [7:0] vecLow_reg;     // first fetched byte
    logic       grantNow;       // grant this cycle
    logic [2:0] winner;         // priority encoder result
    logic       anyReq;         // unmasked pending present
    logic [5:0] active;         // pending and enabled

    assign active = reqEdge_reg[5:0] & mask_reg;  // [R7]

    // priority: rotate starting point by priority register
    always_comb
    begin
        winner = 3'h0;
        anyReq = 1'b0;
        for (int k = `NUM_REQ - 1; k >= 0; k--)
        begin
            int idx;
            idx = (k + int'(priority_reg)) % `NUM_REQ;
            if (active[idx])
            begin
                winner = 3'(idx);                  // [R4]
                anyReq = 1'b1;
            end
        end
    end
    assign grantNow = (state_reg == ST_IDLE) & anyReq & globalEn_reg;

    // next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:  if (grantNow) state_next = ST_SAVE;
            ST_SAVE:  state_next = ST_FETCH;
            ST_FETCH: if (vecReady && vecAddr[0]) state_next = ST_JUMP;
            ST_JUMP:  state_next = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // vector table lookup
    function automatic logic [15:0] vecOf(input logic [2:0] s);
        unique case (s)
            3'h0:    vecOf = `VEC_ZERO;   // [R1]
            3'h1:    vecOf = `VEC_ONE;    // [R2]
            3'h2:    vecOf = `VEC_TWO;    // [R1]
            3'h3:    vecOf = `VEC_THREE;  // [R3]
            3'h4:    vecOf = `VEC_FOUR;   // [R3]
            3'h5:    vecOf = `VEC_FIVE;   // [R3]
            default: vecOf = `VEC_ZERO;   // codes 6, 7 never granted
        endcase
    endfunction

    // fetch sequencing: even byte then the following odd byte
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            grantSrc_reg <= 3'h0;
            vecAddr      <= `RST_VEC;
            vecLow_reg   <= `RST_BYTE;
            vector_reg   <= `RST_VEC;
        end
        else if (grantNow)
        begin
            grantSrc_reg <= winner;
            vecAddr      <= vecOf(winner);
        end
        else if (state_reg == ST_FETCH && vecReady)
        begin
            if (!vecAddr[0])
            begin
                vecLow_reg <= vecByte;
                vecAddr    <= vecAddr + 16'h0001;   // [R6]
            end
            else
                vector_reg <= {vecLow_reg, vecByte}; // [R6]
        end
    end
    assign vecFetch = (state_reg == ST_FETCH);

    // core request outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            coreReq <= '0;
        else
        begin
            coreReq.save   <= (state_reg == ST_SAVE);   // [R5]
            coreReq.branch <= (state_reg == ST_JUMP);   // [R6]
            coreReq.vector <= vector_reg;
            coreReq.source <= grantSrc_reg;
        end
    end

    // global enable: machine cycle disables, software re-enables
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            globalEn_reg <= 1'b0;
        else if (grantNow)
            globalEn_reg <= 1'b0;                        // [R5]
        else if (apbWrite && paddr == `OFS_CORE_CTRL)
            globalEn_reg <= pwdata[`BIT_GLOBAL_EN];
    end

    // pending next: write replaces, grant clears the winner
    logic       reqWrite;      // software write of request register
    logic [5:0] pendNext;      // pending bits before new events
    assign reqWrite = apbWrite && paddr == `OFS_REQ_EDGE;
    always_comb
    begin
        pendNext = reqWrite ? pwdata[5:0] : reqEdge_reg[5:0]; // [R14]
        if (grantNow)
            pendNext[winner] = 1'b0;                    // [R14]
    end

    // request register: edge bits written, a new event wins over clear
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            reqEdge_reg <= `RST_BYTE;
        else
        begin
            if (reqWrite)
                reqEdge_reg[7:6] <= pwdata[7:6];
            reqEdge_reg[5:0] <= pendNext | event_w;     // [R14] [R7]
        end
    end

    // plain configuration registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            priority_reg  <= `RST_PRIO;
            mask_reg      <= 6'h00;
            port3Mode_reg <= `RST_BYTE;
            coreCtrl_reg  <= 2'h0;
            intMask_reg   <= 2'h0;
        end
        else if (apbWrite)
        begin
            unique case (paddr)
                `OFS_PRIORITY:   priority_reg  <= pwdata[2:0];
                `OFS_MASK:       mask_reg      <= pwdata[5:0];
                `OFS_PORT3_MODE: port3Mode_reg <= pwdata[7:0];
                `OFS_CORE_CTRL:  coreCtrl_reg  <= pwdata[1:0];
                `OFS_INT_MASK:   intMask_reg   <= pwdata[1:0];
                default:         ;
            endcase
        end
    end

    // sticky status: bit0 grant, bit1 vector assembled; set wins
    logic [1:0] statSet;
    assign statSet = {coreReq.branch, state_reg == ST_SAVE};
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            intStat_reg <= 2'h0;
        else if (apbWrite && paddr == `OFS_INT_STAT)
            intStat_reg <= (intStat_reg & ~pwdata[1:0]) | statSet;
        else
            intStat_reg <= intStat_reg | statSet;
    end
    assign irq = |(intStat_reg & intMask_reg);

    // read mux, registered data out
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `OFS_REQ_EDGE:   prdata <= {24'h0, reqEdge_reg};
                `OFS_PRIORITY:   prdata <= {29'h0, priority_reg};
                `OFS_MASK:       prdata <= {26'h0, mask_reg};
                `OFS_PORT3_MODE: prdata <= {24'h0, port3Mode_reg};
                `OFS_PIN_LEVEL:  prdata <= {29'h0, srcOne, srcTwo,
                                            srcZero};     // [R11]
                `OFS_VECTOR:     prdata <= {16'h0, vector_reg};
                `OFS_INT_STAT:   prdata <= {30'h0, intStat_reg};
                `OFS_INT_MASK:   prdata <= {30'h0, intMask_reg};
                `OFS_CORE_CTRL:  prdata <= {30'h0, coreCtrl_reg[1],
                                            globalEn_reg};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // grant always clears global enable next cycle
    a_grant_disables: assert property ( // [R5]
        @(posedge clk_sys) disable iff (rst)
        grantNow |=> !globalEn_reg) else $error("grant kept enable");
    // save pulse two cycles after grant
    a_save_timing: assert property ( // [R5]
        @(posedge clk_sys) disable iff (rst)
        grantNow |-> ##2 coreReq.save) else $error("no save pulse");
    // masked events still latch
    a_masked_latch: assert property ( // [R7] [R14]
        @(posedge clk_sys) disable iff (rst)
        event_w[3] |=> reqEdge_reg[3]) else $error("event lost");
    // winner is pending and enabled
    a_winner_valid: assert property ( // [R4]
        @(posedge clk_sys) disable iff (rst)
        grantNow |-> active[winner]) else $error("bad winner");
    // first vector byte address matches the source granted last cycle
    a_vector_addr: assert property ( // [R1] [R2] [R3]
        @(posedge clk_sys) disable iff (rst)
        grantNow |=> vecAddr == {12'h0, $past(winner), 1'b0})
        else $error("bad vector address");
    // request one never fires on rising pin
    a_one_falling: assert property ( // [R2]
        @(posedge clk_sys) disable iff (rst)
        event_w[1] |-> !srcOne) else $error("rising request one");
    // code 00 gives falling only on request zero
    a_edge_decode: assert property ( // [R10] [R9]
        @(posedge clk_sys) disable iff (rst)
        (event_w[0] && !eTwo && !eZero) |-> !srcZero)
        else $error("edge decode wrong");
    // analog on: comparator one feeds two, comparator two feeds zero
    a_analog_route: assert property ( // [R8] [R12]
        @(posedge clk_sys) disable iff (rst)
        analogOn |-> srcTwo == pinSync_reg[4] && srcZero == pinSync_reg[5])
        else $error("bad route");
    // branch carries assembled 16-bit vector
    a_branch_vec: assert property ( // [R6]
        @(posedge clk_sys) disable iff (rst)
        coreReq.branch |-> coreReq.vector == vector_reg)
        else $error("branch vector wrong");
    // timer input selection
    a_timer_sel: assert property ( // [R13]
        @(posedge clk_sys) disable iff (rst)
        !coreCtrl_reg[1] |-> timerInput == pinSync_reg[0])
        else $error("timer input wrong");
endmodule // vectored_irq

// ### bench/core_model.sv
/*
 * core sequencer model: answers vector fetches with program bytes.
 * assumes vecAddr holds while vecFetch is high and no ready shows.
 */
`timescale 1ns/1ns
module core_model
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        vecFetch,
    input  wire logic [15:0] vecAddr,
    input  wire logic        slow,
    output logic      [7:0]  vecByte,
    output logic             vecReady
);
    logic [1:0] waitCnt;   // cycles spent before answering

    // one byte per fetch, either prompt or three cycles late
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            vecReady <= 1'b0;
            vecByte  <= 8'h00;
            waitCnt  <= 2'h0;
        end
        else if (vecFetch && !vecReady && (!slow || waitCnt == 2'h3))
        begin
            // program bytes follow 0x50 plus the byte address
            vecReady <= 1'b1;
            vecByte  <= 8'h50 + vecAddr[7:0];
            waitCnt  <= 2'h0;
        end
        else
        begin
            // stale byte keeps moving so a late sample cannot match
            vecReady <= 1'b0;
            vecByte  <= ~vecByte;
            waitCnt  <= (vecFetch && !vecReady) ? waitCnt + 2'h1 : 2'h0;
        end
    end
endmodule // core_model

// ### bench/testbench.sv
/*
 * self-checking bench of the vectored interrupt block over apb.
 * assumes irq_pkg, vectored_irq and core_model compiled before it.
 */
`timescale 1ns/1ns
`include "irq_consts.svh"
module testbench
    import irq_pkg::*;
;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;                   // apb byte address
    logic [31:0] pwdata, prdata, rd;      // write, read, last read
    logic        err, slow, vecReady, vecFetch, timerInput, irq;
    logic [8:0]  src;                     // pins and event sources
    logic [7:0]  vecByte;                 // byte from core model
    logic [15:0] vecAddr;                 // fetch address
    core_req_t   coreReq;                 // grant request to core
    int          nErrors, checks;         // mismatch and compare counts

    vectored_irq dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparatorPinOne(src[0]),
        .comparatorPinTwo(src[1]), .referencePinThree(src[2]),
        .portTwoBitZero(src[3]), .analogComparatorOne(src[4]),
        .analogComparatorTwo(src[5]), .sixteenBitTimer(src[6]),
        .eightBitTimer(src[7]), .lowVoltageDetector(src[8]),
        .vecByte(vecByte), .vecReady(vecReady), .coreReq(coreReq),
        .vecFetch(vecFetch), .vecAddr(vecAddr),
        .timerInput(timerInput), .irq(irq));
    core_model core_u (.clk_sys(clk_sys), .rst(rst), .vecFetch(vecFetch),
        .vecAddr(vecAddr), .slow(slow), .vecByte(vecByte),
        .vecReady(vecReady));

    // 50 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no wait-state count assumed: only the watchdog ends this wait
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'(pready), 32'h1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk(nm, rd, exp);
    endtask

    // new source levels, then room for sync, detect and latch
    task automatic drv(input logic [8:0] v);
        @(posedge clk_sys);
        src <= v;
        repeat (6) @(posedge clk_sys);
    endtask

    // wait for save then branch, bounded
    task automatic grant(input logic [2:0] s, input logic [15:0] v);
        logic saw = 1'b0;
        int   n   = 0;
        while (coreReq.branch !== 1'b1 && n < 60)
        begin
            @(posedge clk_sys);
            n++;
            if (coreReq.save === 1'b1)
                saw = 1'b1;
        end
        // a grant that never branches is a hang: count it and stop
        if (n >= 60)
        begin
            nErrors++;
            final_report;
        end
        chk("save pulse", 32'(saw), 32'h1);
        chk("vector", 32'(coreReq.vector), 32'(v));
        chk("source", 32'(coreReq.source), 32'(s));
    endtask

    task automatic t_reset;
        logic [11:0] ofs[9] = '{`OFS_REQ_EDGE, `OFS_PRIORITY, `OFS_MASK,
            `OFS_PORT3_MODE, `OFS_PIN_LEVEL, `OFS_VECTOR, `OFS_INT_STAT,
            `OFS_INT_MASK, `OFS_CORE_CTRL};
        foreach (ofs[i])
            rdc("reset value", ofs[i], 32'h0);
        wr(`OFS_VECTOR, 32'hffff);
        rdc("vector read only", `OFS_VECTOR, 32'h0);
        apb(1'b0, 12'h100, 32'h0, rd, err);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_edges;
        for (int c = 0; c < 4; c++)
        begin
            logic [1:0] k;
            k = 2'(c);
            wr(`OFS_REQ_EDGE, {24'h0, k, 6'h0});
            drv(9'h003);
            rdc("rise", `OFS_REQ_EDGE, {24'h0, k, 3'h0, k[1], 1'b0, k[0]});
            wr(`OFS_REQ_EDGE, {24'h0, k, 6'h0});
            drv(9'h000);
            rdc("fall", `OFS_REQ_EDGE, {24'h0, k, 3'h0, ~k[1] | &k, 1'b0,
                ~k[0] | &k});
        end
        wr(`OFS_REQ_EDGE, 32'h0);
        drv(9'h004);
        rdc("one rise", `OFS_REQ_EDGE, 32'h0);
        drv(9'h000);
        rdc("one fall", `OFS_REQ_EDGE, 32'h2);
        $display("test edges done");
    endtask

    task automatic t_prio;
        wr(`OFS_REQ_EDGE, 32'h0);
        drv(9'h1c0);
        drv(9'h000);
        rdc("masked latch", `OFS_REQ_EDGE, 32'h38);
        wr(`OFS_PRIORITY, 32'h5);
        wr(`OFS_MASK, 32'h3f);
        wr(`OFS_CORE_CTRL, 32'h1);
        grant(3'h5, 16'h5a5b);
        rdc("global off", `OFS_CORE_CTRL, 32'h0);
        rdc("pending left", `OFS_REQ_EDGE, 32'h18);
        slow <= 1'b1;
        wr(`OFS_PRIORITY, 32'h4);
        wr(`OFS_CORE_CTRL, 32'h1);
        grant(3'h4, 16'h5859);
        wr(`OFS_PRIORITY, 32'h0);
        wr(`OFS_CORE_CTRL, 32'h1);
        grant(3'h3, 16'h5657);
        rdc("vector reg", `OFS_VECTOR, 32'h5657);
        slow <= 1'b0;
        $display("test priority done");
    endtask

    task automatic t_irq;
        rdc("status", `OFS_INT_STAT, 32'h3);
        @(posedge clk_sys);
        chk("irq masked", 32'(irq), 32'h0);
        wr(`OFS_INT_MASK, 32'h3);
        @(posedge clk_sys);
        chk("irq raised", 32'(irq), 32'h1);
        wr(`OFS_INT_STAT, 32'h1);
        rdc("w1c one bit", `OFS_INT_STAT, 32'h2);
        wr(`OFS_INT_STAT, 32'h2);
        @(posedge clk_sys);
        chk("irq cleared", 32'(irq), 32'h0);
        $display("test interrupt done");
    endtask

    task automatic t_analog;
        wr(`OFS_PORT3_MODE, 32'h2);
        wr(`OFS_REQ_EDGE, 32'hc0);
        drv(9'h020);
        rdc("ac2 to zero", `OFS_REQ_EDGE, 32'hc1);
        wr(`OFS_REQ_EDGE, 32'hc0);
        drv(9'h030);
        rdc("ac1 to two", `OFS_REQ_EDGE, 32'hc4);
        wr(`OFS_PORT3_MODE, 32'h0);
        wr(`OFS_REQ_EDGE, 32'hc0);
        drv(9'h000);
        rdc("analog off", `OFS_REQ_EDGE, 32'hc0);
        drv(9'h007);
        rdc("pin levels", `OFS_PIN_LEVEL, 32'h7);
        chk("tin from pin", 32'(timerInput), 32'h1);
        wr(`OFS_CORE_CTRL, 32'h2);
        @(posedge clk_sys);
        chk("tin from port2", 32'(timerInput), 32'h0);
        drv(9'h008);
        chk("tin port2 high", 32'(timerInput), 32'h1);
        $display("test analog done");
    endtask

    // main sequence
    initial
    begin
        {rst, psel, penable, pwrite, slow} = 5'b10000;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        src     = 9'h000;
        nErrors = 0;
        checks  = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_edges;
        t_prio;
        t_irq;
        t_analog;
        final_report;
    end

    // watchdog, well beyond the few hundred cycles the tests take
    initial
    begin
        #400000;
        nErrors++;
        final_report;
    end
endmodule // testbench
